// ### verilog/drive_ref_params.svh
// Register map, field positions, reset values and timing of the drive reference logic
`ifndef DRIVE_REF_PARAMS_SVH
`define DRIVE_REF_PARAMS_SVH
// Register indexes; byte address is four times the index
`define NREG 11
`define REG_CFG 4'h0
`define REG_FREQA 4'h1
`define REG_FREQB 4'h2
`define REG_VOLTA 4'h3
`define REG_VOLTB 4'h4
`define REG_MOTOR 4'h5
`define REG_BRAKE 4'h6
`define REG_BTIME 4'h7
`define REG_LIMIT 4'h8
`define REG_JUMPA 4'h9
`define REG_JUMPB 4'hA
`define REG_STATUS 4'hB
// Field positions
`define F_LO 11:0
`define F_HI 27:16
`define B0 7:0
`define B1 15:8
`define B2 23:16
`define F_SEL 3:0
`define F_LIMIT 11:8
`define F_MFO0 20:16
`define F_MFO1 25:21
`define F_MFO2 30:26
// Reset values
`define RST_CFG 32'h0000_0000
`define RST_FREQA 32'h0258_0258
`define RST_FREQB 32'h000F_000F
`define RST_VOLTA 32'h0078_08FC
`define RST_VOLTB 32'h0000_0050
`define RST_MOTOR 32'h0000_1E64
`define RST_BRAKE 32'h0032_000F
`define RST_BTIME 32'h0000_0000
`define RST_LIMIT 32'h0000_0064
`define RST_JUMPA 32'h0000_0000
`define RST_JUMPB 32'h0010_0000
`define USER_CURVE 4'hF
`define MFO_RESTART 5'h0A
// Timing
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 100_000_000
`define RAMP_STEP_NS 100_000
`define CLEAR_TIME_MIN 10
`define CLEAR_TICKS (`CLEAR_TIME_MIN * 60 * (1_000_000_000 / `TICK_PERIOD_NS))
`define RESTART_WAIT_TICKS 10
`endif

// ### verilog/drive_ref_pkg.sv
// Types shared by the drive reference logic
`include "drive_ref_params.svh"
package drive_ref_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_SBRK = 6'b00_0010,
    ST_RUN = 6'b00_0100,
    ST_SSTOP = 6'b00_1000,
    ST_RESTART = 6'b01_0000,
    ST_TRIP = 6'b10_0000
  } drive_state_type;
  typedef enum logic [2:0] {
    FLT_NONE = 3'h0,
    FLT_OVERCURRENT = 3'h1,
    FLT_GROUND = 3'h2,
    FLT_OVERVOLT = 3'h3
  } fault_code_type;
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
  } div_state_type;
  typedef struct packed {
    logic [11:0] held;
  } jump_state_type;
  typedef struct packed {
    logic [`NREG-1:0][31:0] cfg;
    drive_state_type st;
    logic [23:0] tdiv;
    logic [15:0] rdiv;
    logic [7:0] tmr;
    logic [12:0] norm;
    logic [3:0] rcount;
    logic [11:0] ramp;
    logic [11:0] slip;
    logic dstart;
    logic pready;
    logic slverr;
    logic [31:0] prdata;
    logic [2:0] err;
    logic [11:0] freq_out;
    logic gate;
    logic brake;
    logic [7:0] brake_cur;
    logic [7:0] thermal;
    logic user_curve;
    logic vf_linear;
    logic restart;
    logic [2:0] mfo;
    logic trip;
  } ref_state_type;
endpackage

// ### verilog/slip_divider.sv
// Iterative unsigned divider for the slip compensation term
`timescale 1ns/1ps
`default_nettype none
module slip_divider
  import drive_ref_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [31:0] num_i,
  input wire logic [31:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] quo_o
);
  div_state_type q, d;

  always_comb begin
    logic [31:0] r;
    logic [31:0] qq;
    r = 32'h0000_0000;
    qq = 32'h0000_0000;
    d = q;
    d.done = 1'b0;
    if (!q.busy && start_i) begin
      d.busy = 1'b1;
      d.cnt = 6'h00;
      d.rem = 32'h0000_0000;
      d.quo = num_i;
      d.den = den_i;
    end else if (q.busy) begin
      // Remainder stays below the divisor, so the shift cannot overflow
      {r, qq} = {q.rem[30:0], q.quo, 1'b0};
      if (r >= q.den) begin
        r = r - q.den;
        qq[0] = 1'b1;
      end
      d.rem = r;
      d.quo = qq;
      d.cnt = q.cnt + 6'h01;
      if (q.cnt == 6'h1F) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy_o = q.busy;
  assign done_o = q.done;
  assign quo_o = q.quo;
endmodule // slip_divider
`default_nettype wire

// ### verilog/jump_band_hold.sv
// Holds a frequency target just outside any active jump band
`timescale 1ns/1ps
`default_nettype none
module jump_band_hold
  import drive_ref_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] target_i,
  input wire logic [2:0][11:0] point_i,
  input wire logic [7:0] width_i,
  output logic [11:0] held_o
);
  jump_state_type q, d;

  always_comb begin
    logic [11:0] t;
    logic [11:0] lo;
    logic [11:0] hi;
    t = target_i;
    lo = 12'h000;
    hi = 12'h000;
    for (int i = 0; i < 3; i++) begin
      lo = (point_i[i] > {4'h0, width_i}) ? point_i[i] - {4'h0, width_i} : 12'h000;
      hi = point_i[i] + {4'h0, width_i};
      // Zero width or zero centre leaves the band off
      if (width_i != 8'h00 && point_i[i] != 12'h000 && t >= lo && t <= hi) begin
        t = (t < point_i[i] && lo != 12'h000) ? lo - 12'h001 : hi + 12'h001;
      end
    end
    d.held = t;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign held_o = q.held;
endmodule // jump_band_hold
`default_nettype wire

// ### verilog/drive_freq_ref.sv
// Frequency reference, braking sequence and fault restart logic of a drive
// Operation
// - Fixed curves 0-14, user points at 15
// - Flag curve error on frequency order
// - Flag curve error on voltage order
// - Mid equals min: straight segment, mid ignored
// - Rated current 10-200%, thermal reference
// - No-load current 0-99% of rated
// - Slip scaled by current above no-load
// - Slip 0.0-9.9% of base, zero disables
// - No slip below minimum or regenerating
// - Brake current in percent of drive
// - Stop braking starts at max(start, min)
// - Zero start time: start at minimum
// - Zero stop time: block below start frequency
// - Bounds percent of maximum, clamp command
// - Flag bounds when upper not above lower
// - Zero command runs at lower bound
// - Never settle in band, ramp smoothly
// - Zero width or centre disables jump
// - Flag jump points out of order
// - Restart only after three fault kinds
// - Count restarts, clear on three events
// - Restart output on while restart runs
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module drive_freq_ref
  import drive_ref_pkg::*;
#(
  parameter int unsigned TICK_CYC = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int unsigned RAMP_CYC = `RAMP_STEP_NS / `CLK_PERIOD_NS,
  parameter int unsigned CLEAR_TICKS = `CLEAR_TICKS,
  parameter int unsigned RESTART_TICKS = `RESTART_WAIT_TICKS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire apb_req_type apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic run_i,
  input wire logic [11:0] freq_cmd_i,
  input wire logic [7:0] out_current_i,
  input wire logic regen_i,
  input wire logic fault_valid_i,
  input wire logic [2:0] fault_code_i,
  input wire logic fault_reset_i,
  output logic [11:0] freq_out_o,
  output logic gate_en_o,
  output logic dc_brake_o,
  output logic [7:0] dc_brake_current_o,
  output logic [7:0] thermal_ref_o,
  output logic user_curve_o,
  output logic vf_linear_o,
  output logic restart_active_o,
  output logic [2:0] mfo_o,
  output logic trip_o
);
  ref_state_type q, d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] pct_scale(input logic [11:0] base, input logic [7:0] pct);
    logic [19:0] p;
    p = 20'(base) * 20'(pct);
    return 12'(p / 20'd100);
  endfunction

  function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[12] ? 12'hFFF : s[11:0];
  endfunction

  function automatic logic [31:0] reg_mask(input logic [3:0] idx);
    case (idx)
      `REG_CFG: reg_mask = 32'h7FFF_0F0F;
      `REG_VOLTB: reg_mask = 32'h0000_0FFF;
      `REG_MOTOR: reg_mask = 32'h00FF_FFFF;
      `REG_BRAKE: reg_mask = 32'h00FF_0FFF;
      `REG_BTIME: reg_mask = 32'h0000_FFFF;
      `REG_LIMIT: reg_mask = 32'h0000_FFFF;
      `REG_JUMPB: reg_mask = 32'h00FF_0FFF;
      default: reg_mask = 32'h0FFF_0FFF;
    endcase
  endfunction

  // ****************************************
  // Settings
  // ****************************************
  wire logic [3:0] curve_sel = q.cfg[`REG_CFG][`F_SEL];
  wire logic [3:0] rs_limit = q.cfg[`REG_CFG][`F_LIMIT];
  wire logic [11:0] fmax = q.cfg[`REG_FREQA][`F_LO];
  wire logic [11:0] fbase = q.cfg[`REG_FREQA][`F_HI];
  wire logic [11:0] fmid = q.cfg[`REG_FREQB][`F_LO];
  wire logic [11:0] fmin = q.cfg[`REG_FREQB][`F_HI];
  wire logic [11:0] vmax = q.cfg[`REG_VOLTA][`F_LO];
  wire logic [11:0] vmid = q.cfg[`REG_VOLTA][`F_HI];
  wire logic [11:0] vmin = q.cfg[`REG_VOLTB][`F_LO];
  wire logic [7:0] rated = q.cfg[`REG_MOTOR][`B0];
  wire logic [7:0] noload = q.cfg[`REG_MOTOR][`B1];
  wire logic [7:0] slip_set = q.cfg[`REG_MOTOR][`B2];
  wire logic [11:0] brk_set = q.cfg[`REG_BRAKE][`F_LO];
  wire logic [7:0] brk_cur = q.cfg[`REG_BRAKE][`B2];
  wire logic [7:0] stop_time = q.cfg[`REG_BTIME][`B0];
  wire logic [7:0] start_time = q.cfg[`REG_BTIME][`B1];
  wire logic [7:0] upper = q.cfg[`REG_LIMIT][`B0];
  wire logic [7:0] lower = q.cfg[`REG_LIMIT][`B1];
  wire logic [2:0][11:0] jpts = {q.cfg[`REG_JUMPB][`F_LO], q.cfg[`REG_JUMPA][`F_HI],
                                 q.cfg[`REG_JUMPA][`F_LO]};
  wire logic [7:0] jwidth = q.cfg[`REG_JUMPB][`B2];

  // ****************************************
  // Derived values
  // ****************************************
  wire logic [11:0] upper_f = pct_scale(fmax, upper);
  wire logic [11:0] lower_f = pct_scale(fmax, lower);
  wire logic [7:0] i0 = pct_scale({4'h0, rated}, noload)[7:0];
  wire logic [11:0] brk_f = (brk_set < fmin) ? fmin : brk_set;
  wire logic user = (curve_sel == `USER_CURVE);
  // A zero command with an unusable lower bound keeps the drive stopped
  wire logic run_ok = run_i && !(freq_cmd_i == 12'h000 && lower_f < fmin);
  wire logic go = run_ok && !(user && q.err[0]);
  wire logic restartable = (fault_code_i == FLT_OVERCURRENT) || (fault_code_i == FLT_GROUND)
                           || (fault_code_i == FLT_OVERVOLT);
  wire logic tick = (q.tdiv == 24'(TICK_CYC - 1));
  wire logic rstep = (q.rdiv == 16'(RAMP_CYC - 1));
  wire logic stop_now = !run_i && ((stop_time == 8'h00) ? (q.ramp < brk_f) : (q.ramp <= brk_f));
  wire logic slip_en = (slip_set != 8'h00) && (out_current_i > i0)
                       && (freq_cmd_i >= fmin) && !regen_i;
  logic [11:0] tgt;
  logic [11:0] held;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quo;

  always_comb begin
    if (!run_i) begin
      tgt = 12'h000;
    end else if (freq_cmd_i == 12'h000 || freq_cmd_i < lower_f) begin
      tgt = lower_f;
    end else if (freq_cmd_i > upper_f) begin
      tgt = upper_f;
    end else begin
      tgt = freq_cmd_i;
    end
  end

  jump_band_hold u_jump (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .target_i(tgt),
    .point_i(jpts),
    .width_i(jwidth),
    .held_o(held)
  );

  // Slip in 0.1 Hz: slip(0.1%) * base * (I - I0) / (1000 * (Ir - I0))
  slip_divider u_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(q.dstart),
    .num_i(32'(slip_set) * 32'(fbase) * 32'(out_current_i - i0)),
    .den_i(32'(10'd1000) * 32'(rated - i0)),
    .busy_o(div_busy),
    .done_o(div_done),
    .quo_o(div_quo)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [3:0] idx;
    logic [31:0] w;
    logic [31:0] nw;
    idx = apb_i.paddr[5:2];
    w = apb_i.pwdata;
    nw = q.cfg[idx];
    d = q;
    d.pready = 1'b0;
    d.slverr = 1'b0;
    d.dstart = 1'b0;
    // One wait state keeps read data coming out of a flop
    if (apb_i.psel && apb_i.penable && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      if (apb_i.paddr[7:6] != 2'b00 || apb_i.paddr[1:0] != 2'b00 || idx > `REG_STATUS) begin
        d.slverr = 1'b1;
      end else if (idx == `REG_STATUS) begin
        d.prdata = {10'h000, q.st, 4'h0, q.rcount, 5'h00, q.err};
      end else begin
        d.prdata = q.cfg[idx];
        if (apb_i.pwrite) begin
          nw = w;
          if (idx == `REG_MOTOR) begin
            nw = q.cfg[idx];
            if (w[`B0] >= 8'd10 && w[`B0] <= 8'd200) begin
              nw[`B0] = w[`B0];
            end
            if (w[`B1] <= 8'd99) begin
              nw[`B1] = w[`B1];
            end
            if (w[`B2] <= 8'd99) begin
              nw[`B2] = w[`B2];
            end
          end else if (idx == `REG_LIMIT) begin
            nw = q.cfg[idx];
            if (w[`B0] <= 8'd100) begin
              nw[`B0] = w[`B0];
            end
            if (w[`B1] <= 8'd100) begin
              nw[`B1] = w[`B1];
            end
          end
          d.cfg[idx] = nw & reg_mask(idx);
        end
      end
    end

    d.err[0] = !(fmax >= fbase && fbase > fmid && fmid >= fmin)
               || !(vmax >= vmid && vmid > vmin);
    d.err[1] = !(upper > lower);
    d.err[2] = !(jpts[0] >= jpts[1] && jpts[1] >= jpts[2]);

    d.tdiv = tick ? 24'h00_0000 : q.tdiv + 24'h00_0001;
    d.rdiv = rstep ? 16'h0000 : q.rdiv + 16'h0001;

    // Slip term is recomputed continuously; disable acts at once
    if (!div_busy && !q.dstart && !div_done) begin
      d.dstart = 1'b1;
    end
    if (!slip_en) begin
      d.slip = 12'h000;
    end else if (div_done) begin
      d.slip = (div_quo[31:12] != 20'h0_0000) ? 12'hFFF : div_quo[11:0];
    end

    // Restart count clears after a long stretch without faults
    if (q.st != ST_TRIP && q.st != ST_RESTART && tick) begin
      if (q.norm == 13'(CLEAR_TICKS - 1)) begin
        d.norm = 13'h0000;
        d.rcount = 4'h0;
      end else begin
        d.norm = q.norm + 13'h0001;
      end
    end

    case (q.st)
      ST_IDLE: begin
        d.ramp = 12'h000;
        d.tmr = 8'h00;
        if (go) begin
          if (start_time == 8'h00) begin
            d.st = ST_RUN;
            d.ramp = fmin;
          end else begin
            d.st = ST_SBRK;
          end
        end
      end
      ST_SBRK: begin
        if (tick) begin
          d.tmr = q.tmr + 8'h01;
        end
        if (q.tmr >= start_time) begin
          d.st = ST_RUN;
          d.ramp = fmin;
          d.tmr = 8'h00;
        end
      end
      ST_RUN: begin
        // Unit steps walk through any band; only the target avoids it
        if (rstep && q.ramp < held) begin
          d.ramp = q.ramp + 12'h001;
        end else if (rstep && q.ramp > held) begin
          d.ramp = q.ramp - 12'h001;
        end
        if (stop_now) begin
          d.tmr = 8'h00;
          d.st = (stop_time == 8'h00) ? ST_IDLE : ST_SSTOP;
        end
      end
      ST_SSTOP: begin
        if (tick) begin
          d.tmr = q.tmr + 8'h01;
        end
        if (q.tmr >= stop_time) begin
          d.st = ST_IDLE;
          d.tmr = 8'h00;
        end
      end
      ST_RESTART: begin
        if (tick) begin
          d.tmr = q.tmr + 8'h01;
        end
        if (q.tmr >= 8'(RESTART_TICKS)) begin
          d.st = ST_RUN;
          d.ramp = fmin;
          d.tmr = 8'h00;
        end
      end
      ST_TRIP: begin
        if (fault_reset_i) begin
          d.st = ST_IDLE;
          d.rcount = 4'h0;
          d.norm = 13'h0000;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // Faults take priority over the sequence
    if (fault_valid_i && q.st != ST_TRIP) begin
      d.norm = 13'h0000;
      d.tmr = 8'h00;
      d.ramp = 12'h000;
      if (restartable && q.rcount < rs_limit) begin
        d.st = ST_RESTART;
        d.rcount = q.rcount + 4'h1;
      end else begin
        d.st = ST_TRIP;
      end
    end

    d.gate = (d.st == ST_RUN);
    d.freq_out = d.gate ? sat_add(d.ramp, d.slip) : 12'h000;
    d.brake = (d.st == ST_SBRK) || (d.st == ST_SSTOP);
    d.brake_cur = d.brake ? brk_cur : 8'h00;
    d.thermal = d.cfg[`REG_MOTOR][`B0];
    d.user_curve = (d.cfg[`REG_CFG][`F_SEL] == `USER_CURVE);
    d.vf_linear = (d.cfg[`REG_FREQB][`F_LO] == d.cfg[`REG_FREQB][`F_HI]);
    d.restart = (d.st == ST_RESTART);
    d.trip = (d.st == ST_TRIP);
    d.mfo[0] = d.restart && (d.cfg[`REG_CFG][`F_MFO0] == `MFO_RESTART);
    d.mfo[1] = d.restart && (d.cfg[`REG_CFG][`F_MFO1] == `MFO_RESTART);
    d.mfo[2] = d.restart && (d.cfg[`REG_CFG][`F_MFO2] == `MFO_RESTART);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.cfg <= {`RST_JUMPB, `RST_JUMPA, `RST_LIMIT, `RST_BTIME, `RST_BRAKE, `RST_MOTOR,
                `RST_VOLTB, `RST_VOLTA, `RST_FREQB, `RST_FREQA, `RST_CFG};
      q.st <= ST_IDLE;
      q.thermal <= 8'h64;
      q.vf_linear <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.slverr;
  assign freq_out_o = q.freq_out;
  assign gate_en_o = q.gate;
  assign dc_brake_o = q.brake;
  assign dc_brake_current_o = q.brake_cur;
  assign thermal_ref_o = q.thermal;
  assign user_curve_o = q.user_curve;
  assign vf_linear_o = q.vf_linear;
  assign restart_active_o = q.restart;
  assign mfo_o = q.mfo;
  assign trip_o = q.trip;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_curve_freq: assert property ((fbase <= fmid) |=> q.err[0])
    else $error("frequency order not flagged");
  a_curve_volt: assert property ((vmid <= vmin) |=> q.err[0])
    else $error("voltage order not flagged");
  a_rated_window: assert property (thermal_ref_o >= 8'd10 && thermal_ref_o <= 8'd200)
    else $error("thermal reference out of range");
  a_noload_cap: assert property (noload <= 8'd99)
    else $error("no-load current above limit");
  a_slip_off: assert property ((regen_i || slip_set == 8'h00) |=> q.slip == 12'h000)
    else $error("slip applied while suppressed");
  a_start_skip: assert property ((q.st == ST_IDLE && go && start_time == 8'h00 && !fault_valid_i)
    |=> (q.st == ST_RUN && q.ramp == $past(fmin) && gate_en_o))
    else $error("direct start not taken");
  a_stop_brake: assert property ((q.st == ST_RUN && stop_now && stop_time != 8'h00
    && !fault_valid_i) |=> (dc_brake_o && dc_brake_current_o == $past(brk_cur)))
    else $error("stop braking not started");
  a_stop_block: assert property ((q.st == ST_RUN && stop_now && stop_time == 8'h00
    && !fault_valid_i) |=> (q.st == ST_IDLE && !gate_en_o && !dc_brake_o))
    else $error("output not blocked");
  a_ramp_smooth: assert property ((q.st == ST_RUN && $past(q.st) == ST_RUN)
    |-> (q.ramp == $past(q.ramp) || q.ramp == $past(q.ramp) + 12'h001
    || q.ramp + 12'h001 == $past(q.ramp)))
    else $error("ramp stepped");
  a_other_fault: assert property ((fault_valid_i && !restartable && q.st != ST_TRIP)
    |=> (q.st == ST_TRIP && trip_o))
    else $error("other fault did not trip");
  a_limit_trip: assert property ((fault_valid_i && restartable && q.rcount >= rs_limit
    && q.st != ST_TRIP) |=> (trip_o && q.rcount == $past(q.rcount)))
    else $error("restart limit not enforced");
  a_restart_out: assert property ((q.st == ST_RESTART) |-> (restart_active_o && !gate_en_o))
    else $error("restart output not driven");
endmodule // drive_freq_ref
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the drive frequency reference block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import drive_ref_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  apb_req_type apb = '0;
  logic run_i = 1'b0;
  logic [11:0] cmd = 12'h000;
  logic fv = 1'b0;
  logic [2:0] fc = 3'h0;
  logic frst = 1'b0;
  logic [7:0] cur = 8'h00;
  logic regen = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, gate_en_o, dc_brake_o, user_curve_o, vf_linear_o;
  logic restart_active_o, trip_o;
  logic [11:0] freq_out_o;
  logic [7:0] dc_brake_current_o, thermal_ref_o;
  logic [2:0] mfo_o;
  logic [31:0] rd;
  logic err;
  logic [31:0] rv [10] = '{32'h0258_0258, 32'h000F_000F, 32'h0078_08FC, 32'h0000_0050,
    32'h0000_1E64, 32'h0032_000F, 32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0010_0000};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  // Short tick and ramp counts keep the run brief
  drive_freq_ref #(.TICK_CYC(10), .RAMP_CYC(2), .CLEAR_TICKS(50), .RESTART_TICKS(2))
  drive_freq_ref_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .run_i(run_i), .freq_cmd_i(cmd),
    .out_current_i(cur), .regen_i(regen), .fault_valid_i(fv), .fault_code_i(fc),
    .fault_reset_i(frst), .freq_out_o(freq_out_o), .gate_en_o(gate_en_o),
    .dc_brake_o(dc_brake_o), .dc_brake_current_o(dc_brake_current_o),
    .thermal_ref_o(thermal_ref_o), .user_curve_o(user_curve_o), .vf_linear_o(vf_linear_o),
    .restart_active_o(restart_active_o), .mfo_o(mfo_o), .trip_o(trip_o));

  always #50 clk_i = ~clk_i;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Values read right after the edge are those sampled at it
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    apb <= '0;
    @(posedge clk_i);
  endtask

  task automatic flt(input logic [2:0] c);
    fv <= 1'b1;
    fc <= c;
    @(posedge clk_i);
    fv <= 1'b0;
    tk(2);
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    tk(4);
    resetn_i <= 1'b1;
    tk(1);
    chk("thermal", 32'd100, thermal_ref_o);
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, 8'(4 * i + 4), 32'h0000_0000);
      chk("reset value", rv[i], rd);
    end
    acc(1'b0, 8'h30, 32'h0000_0000);
    chk("slverr", 32'd1, 32'(err));
    acc(1'b1, 8'h14, 32'h0000_6405);
    acc(1'b0, 8'h14, 32'h0000_0000);
    chk("motor", 32'h0000_1E64, rd);
    acc(1'b1, 8'h00, 32'h000A_010F);
    chk("user curve", 32'd1, 32'(user_curve_o));
    acc(1'b1, 8'h08, 32'h000F_0100);
    chk("linear", 32'd0, 32'(vf_linear_o));
    acc(1'b1, 8'h0C, 32'h0050_08FC);
    acc(1'b0, 8'h2C, 32'h0000_0000);
    chk("volt order", 32'd1, rd & 32'h0000_0007);
    acc(1'b1, 8'h0C, 32'h0078_08FC);
    acc(1'b1, 8'h04, 32'h0258_0064);
    acc(1'b0, 8'h2C, 32'h0000_0000);
    chk("freq order", 32'd1, rd & 32'h0000_0007);
    cmd <= 12'd300;
    run_i <= 1'b1;
    tk(6);
    chk("bad curve gate", 32'd0, 32'(gate_en_o));
    run_i <= 1'b0;
    acc(1'b1, 8'h04, 32'h0258_0258);
    cmd <= 12'd0;
    run_i <= 1'b1;
    tk(6);
    chk("low bound gate", 32'd0, 32'(gate_en_o));
    run_i <= 1'b0;
    acc(1'b1, 8'h20, 32'h0000_1414);
    acc(1'b1, 8'h24, 32'h0064_0032);
    acc(1'b0, 8'h2C, 32'h0000_0000);
    chk("limit jump", 32'd6, rd & 32'h0000_0007);
    acc(1'b1, 8'h20, 32'h0000_0A32);
    acc(1'b1, 8'h24, 32'h0000_00C8);
    run_i <= 1'b1;
    tk(2);
    chk("start", 32'h0000_100F, {gate_en_o, freq_out_o});
    tk(200);
    chk("lower bound", 32'd60, 32'(freq_out_o));
    cmd <= 12'd195;
    tk(400);
    chk("jump hold", 32'd183, 32'(freq_out_o));
    cmd <= 12'd4000;
    tk(400);
    chk("upper bound", 32'd300, 32'(freq_out_o));
    // Slip 5.0% of 60 Hz base, half way from no-load to rated: 1.5 Hz
    acc(1'b1, 8'h14, 32'h0032_1E64);
    cur <= 8'd65;
    tk(100);
    chk("slip on", 32'd315, 32'(freq_out_o));
    regen <= 1'b1;
    tk(3);
    chk("slip regen", 32'd300, 32'(freq_out_o));
    regen <= 1'b0;
    cur <= 8'h00;
    tk(3);
    chk("slip no-load", 32'd300, 32'(freq_out_o));
    flt(3'h3);
    chk("restart", 32'h0000_0011, {restart_active_o, gate_en_o, mfo_o});
    acc(1'b0, 8'h2C, 32'h0000_0000);
    chk("count one", 32'h0010_0100, rd & 32'h003F_0F00);
    tk(30);
    chk("back to run", 32'h0000_0008, {restart_active_o, gate_en_o, mfo_o});
    tk(600);
    acc(1'b0, 8'h2C, 32'h0000_0000);
    chk("count clear", 32'h0000_0000, rd & 32'h0000_0F00);
    run_i <= 1'b0;
    tk(700);
    chk("stop", 32'd0, 32'({gate_en_o, dc_brake_o}));
    flt(3'h1);
    tk(30);
    flt(3'h2);
    chk("limit trip", 32'd2, 32'({trip_o, restart_active_o}));
    frst <= 1'b1;
    tk(2);
    frst <= 1'b0;
    chk("trip clear", 32'd0, 32'(trip_o));
    acc(1'b0, 8'h2C, 32'h0000_0000);
    chk("count reset", 32'h0000_0000, rd & 32'h0000_0F00);
    flt(3'h5);
    chk("other fault", 32'd2, 32'({trip_o, restart_active_o}));
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
